// *** design/dci_interp.sv ***
/*
 * Control-code interpreter: AHB-Lite slave feeding a 16-byte code queue,
 * a byte decoder driving the controller code/data buses, and an 8-byte
 * result queue read back over the bus. Assumes one clock, hclk, shared by
 * the bus master and the disk write path; inputs synchronous to hclk.
 */
// Summary of operation
// - Code 11xxxxxx returns selected register byte
// - Unmapped register read returns zero
// - Code 10xxxxxx writes next byte; unmapped ignored
// - Codes 000xxxxx are commands; 0x00 does nothing
// - Start begins operation from operation register
// - Command 0x04 drops the write gate
// - Command 0x05 drives buses onto ports
// - Command 0x06 and reset restore ports
// - Command 0x07 selects outside write clock
// - Command 0x08 selects inside clock, reset default
// - Commands 0x12/0x14 append CRC/ECC bytes
// - Codes 001xxxxx take one data byte
// - Field flag flips on each syndrome append
// - Command 0x20 flips flag, writes data
// - Command 0x31 writes data mark, masked clocks
// - Commands 0x35/0x39 write header/index marks
// - Repeat code writes byte counted times
// - Multiple code writes counted distinct bytes
// - Clock select holds; inside after reset
// - Auto-boot selects outside clock itself
// - Auto-boot times out after one second
// - Outbound bytes pass a sixteen-byte queue
// - Result bytes pass an eight-byte queue
// - Sixteen-bit counter tracks remaining bytes
`include "dci_defines.svh"
module dci_interp
	import dci_pkg::*;
#(
	parameter int unsigned BOOT_CYC = `DCI_BOOT_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        disk_rdy,
	input  wire logic        rd_vld,
	input  wire logic [7:0]  rd_byte,
	input  wire logic        boot_en,
	input  wire logic        drive_rdy,
	output logic [7:0]       code_bus,
	output logic [7:0]       data_bus,
	output logic [7:0]       clk_mask,
	output logic             bus_stb,
	output logic             append_crc_pair,
	output logic             append_ecc_quad,
	output logic             read_active,
	output logic             write_gate,
	output logic             field_is_data,
	output logic             outside_clk_sel,
	output logic             overrun,
	output logic             boot_timeout,
	output logic [7:0]       port_a_pins,
	output logic             port_a_oe_n,
	output logic [7:0]       port_b_pins,
	output logic             port_b_oe_n
);

	dci_state_s s_ff;
	dci_state_s nxt_s;

	logic [7:0]  ob;
	logic        oempty;
	logic        ofull;
	logic        iempty;
	logic        ifull;
	logic        go;

	// Count decode shared by repeat and multiple codes
	function automatic logic [15:0] cnt_of(input logic [4:0] f);
		logic [15:0] one;
		one = 16'h0001;
		if (f[4])
			cnt_of = one << f[3:0];
		else if (f[3:0] == 4'h0)
			cnt_of = 16'h0010;
		else
			cnt_of = {12'h000, f[3:0]};
	endfunction

	function automatic logic [7:0] reg_rd(input dci_state_s s, input logic [5:0] a);
		case (a)
			`DCI_REG_OPER:     reg_rd = s.oper;
			`DCI_REG_MSK_DATA: reg_rd = s.msk_d;
			`DCI_REG_MSK_HDR:  reg_rd = s.msk_h;
			`DCI_REG_MSK_IDX:  reg_rd = s.msk_i;
			default:           reg_rd = `DCI_RST_BYTE;
		endcase
	endfunction

	always_comb begin
		nxt_s = s_ff;
		nxt_s.stb = 1'b0;
		nxt_s.app2 = 1'b0;
		nxt_s.app4 = 1'b0;
		ob = s_ff.ofifo[s_ff.orp[3:0]];
		oempty = (s_ff.owp == s_ff.orp);
		ofull = (s_ff.owp[3:0] == s_ff.orp[3:0]) && (s_ff.owp[4] != s_ff.orp[4]);
		iempty = (s_ff.iwp == s_ff.irp);
		ifull = (s_ff.iwp[2:0] == s_ff.irp[2:0]) && (s_ff.iwp[3] != s_ff.irp[3]);
		go = !oempty && disk_rdy;

		// Bus slave: one wait state so read data leaves a flop
		if (s_ff.pend) begin
			if (s_ff.pwr) begin
				if (s_ff.paddr == `DCI_OFF_OUT) begin
					if (!ofull) begin
						nxt_s.ofifo[s_ff.owp[3:0]] = hwdata[7:0];
						nxt_s.owp = s_ff.owp + 5'd1;
						nxt_s.pend = 1'b0;
						nxt_s.hrdy = 1'b1;
					end
				end else begin
					nxt_s.pend = 1'b0;
					nxt_s.hrdy = 1'b1;
				end
			end else begin
				nxt_s.pend = 1'b0;
				nxt_s.hrdy = 1'b1;
				nxt_s.hrdat = `DCI_RST_WORD;
				if (s_ff.paddr == `DCI_OFF_IN && !iempty) begin
					nxt_s.hrdat = {23'h00_0000, 1'b1, s_ff.ififo[s_ff.irp[2:0]]};
					nxt_s.irp = s_ff.irp + 4'd1;
				end else if (s_ff.paddr == `DCI_OFF_STATUS) begin
					nxt_s.hrdat = {8'h00, 3'h0, s_ff.owp - s_ff.orp, 4'h0,
						s_ff.iwp - s_ff.irp, s_ff.btmo, s_ff.ovr, s_ff.field,
						s_ff.ext, s_ff.probe, s_ff.wgate, s_ff.rd_on,
						s_ff.st != ST_IDLE};
				end
			end
		end else if (hsel && htrans[1] && hready) begin
			nxt_s.pend = 1'b1;
			nxt_s.pwr = hwrite;
			nxt_s.paddr = haddr[5:2];
			nxt_s.hrdy = 1'b0;
		end

		// Disk read bytes take the result queue first
		if (rd_vld) begin
			if (ifull) begin
				nxt_s.ovr = 1'b1;
			end else begin
				nxt_s.ififo[s_ff.iwp[2:0]] = rd_byte;
				nxt_s.iwp = s_ff.iwp + 4'd1;
			end
		end

		case (s_ff.st)
			ST_IDLE: begin
				if (go) begin
					if (ob[7:6] == 2'b11) begin
						if (!ifull && !rd_vld) begin
							nxt_s.ififo[s_ff.iwp[2:0]] = reg_rd(s_ff, ob[5:0]);
							nxt_s.iwp = s_ff.iwp + 4'd1;
							nxt_s.orp = s_ff.orp + 5'd1;
						end
					end else if (ob[7:5] == 3'b000) begin
						nxt_s.orp = s_ff.orp + 5'd1;
						if (ob != `DCI_CMD_NOP) begin
							nxt_s.stb = 1'b1;
							nxt_s.cbus = ob;
							nxt_s.dbus = `DCI_RST_BYTE;
							nxt_s.mask = `DCI_RST_BYTE;
						end
						case (ob)
							`DCI_CMD_START: begin
								if (s_ff.oper[`DCI_OPER_READ_BIT])
									nxt_s.rd_on = 1'b1;
								else
									nxt_s.wgate = 1'b1;
							end
							`DCI_CMD_GATE_OFF: begin
								nxt_s.wgate = 1'b0;
								nxt_s.rd_on = 1'b0;
							end
							`DCI_CMD_PROBE_ON:  nxt_s.probe = 1'b1;
							`DCI_CMD_PROBE_OFF: nxt_s.probe = 1'b0;
							`DCI_CMD_OUT_CLK:   nxt_s.ext = 1'b1;
							`DCI_CMD_IN_CLK:    nxt_s.ext = 1'b0;
							`DCI_CMD_CRC_PAIR: begin
								nxt_s.app2 = 1'b1;
								nxt_s.field = !s_ff.field;
							end
							`DCI_CMD_ECC_QUAD: begin
								nxt_s.app4 = 1'b1;
								nxt_s.field = !s_ff.field;
							end
							default: ;
						endcase
					end else begin
						nxt_s.code = ob;
						nxt_s.orp = s_ff.orp + 5'd1;
						nxt_s.cnt = cnt_of(ob[4:0]);
						// Multiple code goes straight to data
						nxt_s.st = (ob[7:5] == 3'b011) ? ST_EMIT : ST_ARG;
					end
				end
			end
			ST_ARG: begin
				if (go) begin
					nxt_s.orp = s_ff.orp + 5'd1;
					nxt_s.st = ST_IDLE;
					if (s_ff.code[7]) begin
						case (s_ff.code[5:0])
							`DCI_REG_OPER:     nxt_s.oper = ob;
							`DCI_REG_MSK_DATA: nxt_s.msk_d = ob;
							`DCI_REG_MSK_HDR:  nxt_s.msk_h = ob;
							`DCI_REG_MSK_IDX:  nxt_s.msk_i = ob;
							default: ;
						endcase
					end else begin
						nxt_s.stb = 1'b1;
						nxt_s.cbus = s_ff.code;
						nxt_s.dbus = ob;
						nxt_s.dat = ob;
						nxt_s.mask = `DCI_RST_BYTE;
						case (s_ff.code)
							`DCI_CMD_FLIP_FLD:  nxt_s.field = !s_ff.field;
							`DCI_CMD_DATA_MARK: nxt_s.mask = s_ff.msk_d;
							`DCI_CMD_HDR_MARK:  nxt_s.mask = s_ff.msk_h;
							`DCI_CMD_IDX_MARK:  nxt_s.mask = s_ff.msk_i;
							default: ;
						endcase
						if (s_ff.code[6]) begin
							nxt_s.cnt = s_ff.cnt - 16'd1;
							if (s_ff.cnt != 16'd1)
								nxt_s.st = ST_EMIT;
						end
					end
				end
			end
			ST_EMIT: begin
				if (s_ff.code[5] ? go : disk_rdy) begin
					nxt_s.stb = 1'b1;
					nxt_s.cbus = s_ff.code;
					nxt_s.mask = `DCI_RST_BYTE;
					nxt_s.dbus = s_ff.code[5] ? ob : s_ff.dat;
					if (s_ff.code[5])
						nxt_s.orp = s_ff.orp + 5'd1;
					nxt_s.cnt = s_ff.cnt - 16'd1;
					if (s_ff.cnt == 16'd1)
						nxt_s.st = ST_IDLE;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase

		// Strap caught one edge after reset release, never under reset
		if (!s_ff.boot_seen) begin
			nxt_s.boot_seen = 1'b1;
			nxt_s.boot_run = boot_en;
			if (boot_en)
				nxt_s.ext = 1'b1;
		end else if (s_ff.boot_run) begin
			if (drive_rdy) begin
				nxt_s.boot_run = 1'b0;
			end else if (s_ff.bcnt == 27'(BOOT_CYC - 1)) begin
				nxt_s.boot_run = 1'b0;
				nxt_s.btmo = 1'b1;
			end else begin
				nxt_s.bcnt = s_ff.bcnt + 27'd1;
			end
		end

		nxt_s.pa = nxt_s.probe ? nxt_s.dbus : `DCI_RST_BYTE;
		nxt_s.pb = nxt_s.probe ? nxt_s.cbus : `DCI_RST_BYTE;
		nxt_s.poe_n = !nxt_s.probe;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
			s_ff.hrdy <= 1'b1;
			s_ff.poe_n <= 1'b1;
			s_ff.st <= ST_IDLE;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign hreadyout = s_ff.hrdy;
	assign hresp = s_ff.hresp;
	assign hrdata = s_ff.hrdat;
	assign code_bus = s_ff.cbus;
	assign data_bus = s_ff.dbus;
	assign clk_mask = s_ff.mask;
	assign bus_stb = s_ff.stb;
	assign append_crc_pair = s_ff.app2;
	assign append_ecc_quad = s_ff.app4;
	assign read_active = s_ff.rd_on;
	assign write_gate = s_ff.wgate;
	assign field_is_data = s_ff.field;
	assign outside_clk_sel = s_ff.ext;
	assign overrun = s_ff.ovr;
	assign boot_timeout = s_ff.btmo;
	assign port_a_pins = s_ff.pa;
	assign port_b_pins = s_ff.pb;
	assign port_a_oe_n = s_ff.poe_n;
	assign port_b_oe_n = s_ff.poe_n;

	logic dec;
	assign dec = ce && s_ff.st == ST_IDLE && go;

	a_nop_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == `DCI_CMD_NOP |=> !bus_stb && write_gate == $past(write_gate))
		else $error("nop changed state");
	a_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == `DCI_CMD_GATE_OFF |=> !write_gate && code_bus == 8'h04)
		else $error("write gate stayed on");
	a_probe_pins: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == `DCI_CMD_PROBE_ON |=> !port_a_oe_n && port_b_pins == code_bus)
		else $error("probe mode not on pins");
	a_probe_off: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == `DCI_CMD_PROBE_OFF |=> port_a_oe_n && port_b_oe_n)
		else $error("probe mode not left");
	a_clk_select: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == `DCI_CMD_OUT_CLK |=> outside_clk_sel)
		else $error("outside clock not chosen");
	a_field_flip: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == `DCI_CMD_CRC_PAIR |=> append_crc_pair
			&& field_is_data != $past(field_is_data))
		else $error("append did not flip field");
	a_repeat_count: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob == 8'h58 |=> s_ff.cnt == 16'h0100 && s_ff.st == ST_ARG)
		else $error("repeat count wrong");
	a_rd_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
		dec && ob[7:6] == 2'b11 && ob[5:2] != 4'h0 && !ifull && !rd_vld
		|=> s_ff.ififo[$past(s_ff.iwp[2:0])] == 8'h00)
		else $error("unmapped read not zero");
	a_boot_tmo: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(boot_timeout) |-> s_ff.bcnt == 27'(BOOT_CYC - 1))
		else $error("boot timeout at wrong count");

endmodule

// *** shared/dci_defines.svh ***
/*
 * Constants of the disk control-code interpreter: bus offsets, code values,
 * reset values and timing counts. Included by the package and the
 * interpreter; the guard keeps the second inclusion harmless.
 */
`ifndef DCI_DEFINES_SVH
`define DCI_DEFINES_SVH

`define DCI_CLK_MHZ        100
`define DCI_BOOT_TIME_MS   1000
`define DCI_BOOT_CYC       (`DCI_BOOT_TIME_MS * 1000 * `DCI_CLK_MHZ)

`define DCI_OFF_OUT        4'h0
`define DCI_OFF_IN         4'h1
`define DCI_OFF_STATUS     4'h2

`define DCI_REG_OPER       6'h00
`define DCI_REG_MSK_DATA   6'h01
`define DCI_REG_MSK_HDR    6'h02
`define DCI_REG_MSK_IDX    6'h03
`define DCI_OPER_READ_BIT  7

`define DCI_CMD_NOP        8'h00
`define DCI_CMD_START      8'h01
`define DCI_CMD_GATE_OFF   8'h04
`define DCI_CMD_PROBE_ON   8'h05
`define DCI_CMD_PROBE_OFF  8'h06
`define DCI_CMD_OUT_CLK    8'h07
`define DCI_CMD_IN_CLK     8'h08
`define DCI_CMD_CRC_PAIR   8'h12
`define DCI_CMD_ECC_QUAD   8'h14
`define DCI_CMD_FLIP_FLD   8'h20
`define DCI_CMD_DATA_MARK  8'h31
`define DCI_CMD_HDR_MARK   8'h35
`define DCI_CMD_IDX_MARK   8'h39

`define DCI_RST_BYTE       8'h00
`define DCI_RST_WORD       32'h0000_0000
`define DCI_RST_CNT        16'h0000

`endif

// *** shared/dci_pkg.sv ***
/*
 * Types of the disk control-code interpreter: decoder states and the
 * packed state record. Assumes dci_defines.svh on the include path.
 */
package dci_pkg;
`include "dci_defines.svh"

	typedef enum logic [1:0] {ST_IDLE, ST_ARG, ST_EMIT} dci_state_e;

	typedef struct packed {
		logic              hrdy;
		logic              hresp;
		logic [31:0]       hrdat;
		logic              pend;
		logic              pwr;
		logic [3:0]        paddr;
		logic [15:0][7:0]  ofifo;
		logic [4:0]        owp;
		logic [4:0]        orp;
		logic [7:0][7:0]   ififo;
		logic [3:0]        iwp;
		logic [3:0]        irp;
		dci_state_e        st;
		logic [7:0]        code;
		logic [7:0]        dat;
		logic [15:0]       cnt;
		logic [7:0]        oper;
		logic [7:0]        msk_d;
		logic [7:0]        msk_h;
		logic [7:0]        msk_i;
		logic [7:0]        cbus;
		logic [7:0]        dbus;
		logic [7:0]        mask;
		logic              stb;
		logic              app2;
		logic              app4;
		logic              rd_on;
		logic              wgate;
		logic              probe;
		logic              ext;
		logic              field;
		logic              ovr;
		logic              boot_seen;
		logic              boot_run;
		logic              btmo;
		logic [26:0]       bcnt;
		logic [7:0]        pa;
		logic [7:0]        pb;
		logic              poe_n;
	} dci_state_s;
endpackage

// *** testbench/dci_disk_model.sv ***
/*
 * Disk-side partner: random ready stalls, a short burst of read bytes
 * while a read runs. Assumes one clock and an active-low async reset.
 */
module dci_disk_model #(
	parameter int NBYTES = 3
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic read_active,
	output logic      disk_rdy,
	output logic      rd_vld,
	output logic [7:0] rd_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	logic go;
	assign go = read_active && n < NBYTES && !rd_vld;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			n <= 0;
			disk_rdy <= 1'b0;
			rd_vld <= 1'b0;
			rd_byte <= 8'h00;
		end else begin
			// Stalls a quarter of the time
			disk_rdy <= ($urandom % 4) != 0;
			rd_vld <= go;
			if (go) begin
				rd_byte <= 8'ha0 + 8'(n);
				n <= n + 1;
			end else begin
				// Released line never holds the old byte
				rd_byte <= ~rd_byte;
				if (!read_active) n <= 0;
			end
		end
	end
endmodule

// *** testbench/testbench.sv ***
/*
 * Self-checking bench: AHB-Lite master, byte-stream model, disk partner.
 * Assumes the interpreter with a shortened boot count of 20 cycles.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic        boot_en = 0, drive_rdy = 1;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	wire logic   hrdy, hresp, bus_stb, crc2, ecc4, read_active, write_gate;
	wire logic   field_is_data, outside_clk_sel, boot_timeout, pa_oe_n, pb_oe_n;
	wire logic   disk_rdy, rd_vld, overrun;
	wire logic [31:0] hrdata;
	wire logic [7:0]  code_bus, data_bus, clk_mask, port_a_pins, port_b_pins, rd_byte;
	int          mismatches = 0, checks = 0, cyc = 0, np = 0, k;
	logic [15:0] gotq[$], expq[$];
	logic [7:0]  lmask, d, m;
	logic        f;
	logic [7:0]  cmdt[4] = '{8'h07, 8'h05, 8'h08, 8'h06};
	logic [3:0]  expt[4] = '{4'b1011, 4'b1100, 4'b0100, 4'b0011};
	logic [7:0]  rep[6] = '{8'h40, 8'h4f, 8'h4e, 8'h50, 8'h53, 8'h58};
	logic [7:0]  mul[3] = '{8'h63, 8'h70, 8'h61};
	logic [7:0]  mark[3] = '{8'h31, 8'h35, 8'h39};

	dci_interp #(.BOOT_CYC(20)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
		.hrdata(hrdata), .disk_rdy(disk_rdy), .rd_vld(rd_vld), .rd_byte(rd_byte),
		.boot_en(boot_en), .drive_rdy(drive_rdy), .code_bus(code_bus),
		.data_bus(data_bus), .clk_mask(clk_mask), .bus_stb(bus_stb),
		.append_crc_pair(crc2), .append_ecc_quad(ecc4), .read_active(read_active),
		.write_gate(write_gate), .field_is_data(field_is_data),
		.outside_clk_sel(outside_clk_sel), .overrun(overrun), .boot_timeout(boot_timeout),
		.port_a_pins(port_a_pins), .port_a_oe_n(pa_oe_n),
		.port_b_pins(port_b_pins), .port_b_oe_n(pb_oe_n));
	dci_disk_model disk (.hclk(hclk), .hresetn(hresetn), .read_active(read_active),
		.disk_rdy(disk_rdy), .rd_vld(rd_vld), .rd_byte(rd_byte));

	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		if (bus_stb === 1'b1) begin
			gotq.push_back({code_bus, data_bus});
			lmask = clk_mask;
		end
		if (crc2 === 1'b1) np++;
		if (ecc4 === 1'b1) np += 16;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	function automatic int cnt(input logic [7:0] c);
		return c[4] ? (1 << c[3:0]) : (c[3:0] == 0 ? 16 : int'(c[3:0]));
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_q();
		chk(gotq.size(), expq.size());
		foreach (expq[i]) if (i < gotq.size()) chk(gotq[i], expq[i]);
		gotq.delete();
		expq.delete();
	endtask
	// Address phase held until ready, data phase likewise
	task automatic ahb(input logic w, input logic [3:0] off, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= 32'(off);
		hwrite <= w;
		do @(posedge hclk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task automatic put(input logic [7:0] b);
		ahb(1'b1, 4'h0, 32'(b));
	endtask
	task automatic drain();
		int n = 0;
		do begin
			ahb(1'b0, 4'h8, 0);
			n++;
		end while ((rd[0] !== 1'b0 || rd[20:16] !== 5'h00) && n < 300);
		if (rd[0] !== 1'b0 || rd[20:16] !== 5'h00) begin
			mismatches++;
			$display("MISMATCH t=%0t drain limit", $time);
		end
	endtask
	task automatic res(input logic [7:0] e);
		int n = 0;
		do begin
			ahb(1'b0, 4'h4, 0);
			n++;
		end while (rd[8] !== 1'b1 && n < 50);
		chk(rd, {23'h00_0000, 1'b1, e});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		void'($urandom(44847));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		chk({outside_clk_sel, pa_oe_n, pb_oe_n, hrdy, boot_timeout, hresp}, 6'h1c);
		$display("reset test done");
		d = 8'($urandom);
		put(8'h81);
		put(d);
		put(8'hc1);
		res(d);
		put(8'h85);
		put(~d);
		put(8'hc5);
		res(8'h00);
		$display("register test done");
		foreach (cmdt[i]) begin
			put(cmdt[i]);
			drain();
			chk({rd[4], rd[3], pa_oe_n, pb_oe_n}, expt[i]);
			chk({port_a_pins, port_b_pins}, expt[i][2] ? {data_bus, cmdt[i]} : 16'h0000);
		end
		$display("command test done");
		gotq.delete();
		put(8'h00);
		foreach (rep[i]) begin
			d = 8'($urandom);
			put(rep[i]);
			put(d);
			for (k = 0; k < cnt(rep[i]); k++) expq.push_back({rep[i], d});
		end
		foreach (mul[i]) begin
			put(mul[i]);
			for (k = 0; k < cnt(mul[i]); k++) begin
				d = 8'($urandom);
				put(d);
				expq.push_back({mul[i], d});
			end
		end
		drain();
		chk_q();
		$display("stream test done");
		f = field_is_data;
		put(8'h12);
		drain();
		chk(field_is_data, !f);
		put(8'h14);
		drain();
		chk(field_is_data, f);
		put(8'h20);
		put(8'h4e);
		drain();
		chk({field_is_data, gotq[$][7:0]}, {!f, 8'h4e});
		chk(np, 17);
		foreach (mark[i]) begin
			m = 8'($urandom);
			d = 8'($urandom);
			put(8'h81 + 8'(i));
			put(m);
			put(mark[i]);
			put(d);
			drain();
			chk({lmask, gotq[$][7:0]}, {m, d});
		end
		$display("field and mark test done");
		put(8'h80);
		put(8'h80);
		put(8'h01);
		drain();
		chk({rd[2:1], write_gate, read_active}, 4'b0101);
		for (k = 0; k < 3; k++) res(8'ha0 + 8'(k));
		chk(overrun, 1'b0);
		put(8'h04);
		drain();
		chk({rd[2:1], write_gate, read_active}, 4'b0000);
		put(8'h80);
		put(8'h00);
		put(8'h01);
		drain();
		chk({rd[2:1], write_gate, read_active}, 4'b1010);
		put(8'h04);
		drain();
		chk({rd[2:1], write_gate, read_active}, 4'b0000);
		$display("disk access test done");
		hresetn <= 1'b0;
		boot_en <= 1'b1;
		drive_rdy <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (10) @(posedge hclk);
		chk({outside_clk_sel, boot_timeout}, 2'b10);
		repeat (20) @(posedge hclk);
		chk({outside_clk_sel, boot_timeout}, 2'b11);
		$display("boot test done");
		tally_and_finish();
	end
endmodule
